// ==== fvcsp_pkg.sv ====
// Constants and types of the three-wire configuration port.
// Assumes one system clock; serial pins arrive asynchronous to it.
package fvcsp_pkg;

  // Frame layout
  localparam int ADDR_BITS  = 15;                   // Address field length
  localparam int DATA_BITS  = 8;                    // Data word length
  localparam int INSTR_BITS = 1 + ADDR_BITS;        // Direction plus address
  localparam int CNT_W      = 5;                    // Edge counter width

  // Counter marks
  localparam logic [CNT_W-1:0] INSTR_LAST = 5'h0f;  // Index of last instruction rise
  localparam logic [CNT_W-1:0] DATA_FULL  = 5'h08;  // Data rises in a complete frame
  localparam logic [CNT_W-1:0] DATA_OVER  = 5'h09;  // Saturation: frame too long

  // Fixed device address carried in every frame
  localparam logic [ADDR_BITS-1:0] DEV_ADDR = 15'h0010;

  // Field positions in the data word
  localparam int BIT_CHIP_EN = 7;                   // Chip enable
  localparam int BIT_OFS_EN  = 4;                   // Offset loop enable
  localparam int FREQ_MSB    = 2;                   // Filter code msb
  localparam int FREQ_LSB    = 0;                   // Filter code lsb

  // Codes and reset values
  localparam logic [2:0] CODE_BYPASS = 3'h7;        // Filter bypass code
  localparam logic [7:0] CFG_RESET   = 8'h97;       // Enable, offset on, bypass

  // Transaction states, Gray in the order idle-instr-write-read
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_WDATA = 2'b11,
    ST_RDATA = 2'b10
  } fvcsp_state_t;

endpackage : fvcsp_pkg

// ==== fvcsp_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is a slow level or an edge the caller detects later.
module fvcsp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] metaQ;                          // First stage, read by second only

  // Two stages; reset to a constant idle level
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      metaQ   <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      metaQ   <= asyncIn;
      syncOut <= metaQ;
    end
  end

endmodule : fvcsp_sync

// ==== fvcsp_top.sv ====
// Three-wire serial configuration port: shifts 24-bit frames, holds settings.
// Assumes the host is master of select and serial clock, both oversampled
// by sys_clk; serial clock must stay well below a quarter of sys_clk.
module fvcsp_top (
  // System
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       spiCsN,
  input  wire logic       spiSclk,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOe,
  // Settings
  output logic            chipEnable,
  output logic            offsetLoopEn,
  output logic [2:0]      filterCode,
  output logic            filterBypass
);

  // Reset release
  logic                        rstMetaN;              // First reset stage
  logic                        rstSyncN;              // Reset used everywhere

  // Synchronised pins
  logic [2:0]                  pinSync;               // {cs, sclk, sdio}
  logic                        csS;                   // Select, synced
  logic                        sclkS;                 // Serial clock, synced
  logic                        sdioS;                 // Data in, synced

  // Edge history
  logic                        csPrevQ;
  logic                        sclkPrevQ;
  logic                        csFall;
  logic                        csRise;
  logic                        sclkRise;
  logic                        sclkFall;

  // Transaction state
  fvcsp_pkg::fvcsp_state_t     stateQ, stateD;
  logic [fvcsp_pkg::CNT_W-1:0] bitCntQ, bitCntD;      // Rises taken in phase
  logic [fvcsp_pkg::INSTR_BITS-1:0] instrQ, instrD;   // Direction and address
  logic [7:0]                  dataQ, dataD;          // Write in / read out
  logic                        oeQ, oeD;              // Data line driven
  logic [7:0]                  cfgQ, cfgD;            // Settings register
  logic                        bypassQ, bypassD;      // Decoded bypass
  logic                        commit;                // Full valid write

  // Reset synchroniser: async assert, clocked release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMetaN <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMetaN <= 1'b1;
      rstSyncN <= rstMetaN;
    end
  end

  // Pins cross into sys_clk; select idles high
  fvcsp_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_pinSync (
    .clk     (sys_clk),
    .rstN    (rstSyncN),
    .asyncIn ({spiCsN, spiSclk, sdioIn}),
    .syncOut (pinSync)
  );

  assign csS   = pinSync[2];
  assign sclkS = pinSync[1];
  assign sdioS = pinSync[0];

  // Edge history registers
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      csPrevQ   <= 1'b1;
      sclkPrevQ <= 1'b0;
    end else begin
      csPrevQ   <= csS;
      sclkPrevQ <= sclkS;
    end
  end

  // Edges; sclk edges only count while selected
  assign csFall   = csPrevQ & ~csS;
  assign csRise   = ~csPrevQ & csS;
  assign sclkRise = ~csS & sclkS & ~sclkPrevQ;
  assign sclkFall = ~csS & ~sclkS & sclkPrevQ;

  // valid write frame
  // Commit only on exactly 24 bits with the fixed address
  assign commit = csRise && (stateQ == fvcsp_pkg::ST_WDATA)
               && (bitCntQ == fvcsp_pkg::DATA_FULL)
               && (instrQ[fvcsp_pkg::ADDR_BITS-1:0] == fvcsp_pkg::DEV_ADDR);

  // Next-state logic of the frame engine
  always_comb begin
    stateD  = stateQ;
    bitCntD = bitCntQ;
    instrD  = instrQ;
    dataD   = dataQ;
    oeD     = oeQ;
    if (csRise) begin
      // select ends transaction
      // Any phase returns to idle and frees the line
      stateD  = fvcsp_pkg::ST_IDLE;
      oeD     = 1'b0;
      bitCntD = '0;
    end else if (csFall) begin
      stateD  = fvcsp_pkg::ST_INSTR;
      bitCntD = '0;
      oeD     = 1'b0;
    end else begin
      unique case (stateQ)
        fvcsp_pkg::ST_IDLE: begin
          // Waiting for select
          oeD = 1'b0;
        end
        fvcsp_pkg::ST_INSTR: begin
          if (sclkRise) begin
            instrD  = {instrQ[fvcsp_pkg::INSTR_BITS-2:0], sdioS};
            bitCntD = bitCntQ + 5'h01;
            if (bitCntQ == fvcsp_pkg::INSTR_LAST) begin
              bitCntD = '0;
              if (instrQ[fvcsp_pkg::INSTR_BITS-2]) begin
                stateD = fvcsp_pkg::ST_RDATA;
                oeD    = 1'b1;
                dataD  = cfgQ;
              end else begin
                stateD = fvcsp_pkg::ST_WDATA;
              end
            end
          end
        end
        fvcsp_pkg::ST_WDATA: begin
          if (sclkRise) begin
            dataD = {dataQ[6:0], sdioS};
            if (bitCntQ != fvcsp_pkg::DATA_OVER) begin
              bitCntD = bitCntQ + 5'h01;
            end
          end
        end
        fvcsp_pkg::ST_RDATA: begin
          if (sclkRise && bitCntQ != fvcsp_pkg::DATA_OVER) begin
            bitCntD = bitCntQ + 5'h01;
          end else if (sclkFall && bitCntQ != '0) begin
            // shift on falling edge
            // First fall after turnaround keeps the MSB in place
            dataD = {dataQ[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  // Frame engine registers
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      stateQ  <= fvcsp_pkg::ST_IDLE;
      bitCntQ <= '0;
      instrQ  <= '0;
      dataQ   <= '0;
      oeQ     <= 1'b0;
    end else begin
      stateQ  <= stateD;
      bitCntQ <= bitCntD;
      instrQ  <= instrD;
      dataQ   <= dataD;
      oeQ     <= oeD;
    end
  end

  // Settings next values; one word updates all fields at once
  always_comb begin
    cfgD    = cfgQ;
    bypassD = bypassQ;
    if (commit) begin
      cfgD    = dataQ;
      bypassD = (dataQ[fvcsp_pkg::FREQ_MSB:fvcsp_pkg::FREQ_LSB]
                 == fvcsp_pkg::CODE_BYPASS);
    end
  end

  // power-up defaults
  // Settings registers
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgQ    <= fvcsp_pkg::CFG_RESET;
      bypassQ <= 1'b1;
    end else begin
      cfgQ    <= cfgD;
      bypassQ <= bypassD;
    end
  end

  // Outputs straight from registers
  assign sdioOut      = dataQ[7];
  assign sdioOe       = oeQ;
  assign offsetLoopEn = cfgQ[fvcsp_pkg::BIT_OFS_EN];
  assign chipEnable   = cfgQ[fvcsp_pkg::BIT_CHIP_EN];
  assign filterCode   = cfgQ[fvcsp_pkg::FREQ_MSB:fvcsp_pkg::FREQ_LSB];
  assign filterBypass = bypassQ;

  // Checks of the frame engine
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncN);

  sequence seqLastInstr;
    stateQ == fvcsp_pkg::ST_INSTR && sclkRise && !csRise && !csFall
      && bitCntQ == fvcsp_pkg::INSTR_LAST;
  endsequence

  sequence seqFullWrite;
    csRise && stateQ == fvcsp_pkg::ST_WDATA && bitCntQ == fvcsp_pkg::DATA_FULL
      && instrQ[fvcsp_pkg::ADDR_BITS-1:0] == fvcsp_pkg::DEV_ADDR;
  endsequence

  a_write_dir: assert property (seqLastInstr ##0 !instrQ[fvcsp_pkg::INSTR_BITS-2] |=>
    stateQ == fvcsp_pkg::ST_WDATA && !oeQ)
    else $error("Write direction not taken");

  a_read_turn: assert property (seqLastInstr ##0 instrQ[fvcsp_pkg::INSTR_BITS-2] |=>
    stateQ == fvcsp_pkg::ST_RDATA && oeQ)
    else $error("Read turnaround missing");

  a_instr_len: assert property ($past(stateQ) == fvcsp_pkg::ST_INSTR
    && (stateQ == fvcsp_pkg::ST_WDATA || stateQ == fvcsp_pkg::ST_RDATA)
    |-> $past(bitCntQ) == fvcsp_pkg::INSTR_LAST)
    else $error("Instruction length wrong");

  a_commit_word: assert property (seqFullWrite |=> cfgQ == $past(dataQ))
    else $error("Write not committed");

  a_partial_keep: assert property (csRise && !commit |=> $stable(cfgQ))
    else $error("Partial frame altered settings");

  a_read_msb: assert property ($rose(oeQ) |-> sdioOut == cfgQ[7])
    else $error("Read MSB wrong");

  a_fall_change: assert property (oeQ && $past(oeQ) && $changed(sdioOut)
    |-> $past(sclkFall))
    else $error("Read data changed off a falling edge");

  a_cs_end: assert property (csRise |=> !oeQ
    && stateQ == fvcsp_pkg::ST_IDLE)
    else $error("Select high did not end transaction");

  a_bypass_code: assert property (filterBypass == (filterCode == fvcsp_pkg::CODE_BYPASS))
    else $error("Bypass decode mismatch");

endmodule : fvcsp_top

// ==== fvcsp_tail_unused_marker.sv ====
// Spare compilation unit; holds no module, package or logic.
// Assumes nothing of its surroundings; safe to compile in any order.

// ==== fvcsp_host_model.sv ====
// Host model: master of select, serial clock and data pin of the port.
// Assumes the device drives the data pin only while sdioOe is high.
module fvcsp_host_model (
  // Serial pins
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      sdioIn,
  input  wire logic sdioOut,
  input  wire logic sdioOe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic hostOe  = 1'b1;  // Host drives data pin
  logic hostBit = 1'b0;  // Last bit put out

  // Pin level; a released pin shows the inverse of its last value
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);

  // Idle: deselected, clock parked low
  initial begin
    spiCsN  = 1'b1;
    spiSclk = 1'b0;
  end

  // One frame of nBits clocks at 125 ns; clock stands still between frames
  task automatic frame(input logic [23:0] word, input int nBits,
                       output logic [7:0] rdData, output logic oeSeen);
    logic rd;
    rd     = word[23];
    rdData = 8'h00;
    oeSeen = 1'b0;
    hostOe = 1'b1;
    spiCsN = 1'b0;
    // Half-step offset keeps every sclk edge and the select rise off a sys_clk edge
    #0.5;
    for (int i = 0; i < nBits; i++) begin
      if (!rd || i < 16) begin
        hostBit = word[23-i];
      end
      #62.5 spiSclk = 1'b1;
      if (rd && i >= 16) begin
        rdData = {rdData[6:0], sdioIn};
      end
      #62.5 spiSclk = 1'b0;
      // line must be turned by this fall
      if (rd && i == 15) begin
        oeSeen = sdioOe;
        hostOe = 1'b0;
      end
    end
    #62.5 spiCsN = 1'b1;
    hostOe = 1'b1;
    #250;
  endtask : frame
endmodule : fvcsp_host_model

// ==== tb_fvcsp_top.sv ====
// Testbench of the serial configuration port: writes, reads, refusals.
// Assumes the host model owns the serial pins; bench owns clock and reset.
module tb_fvcsp_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk = 1'b0;  // 100 MHz
  logic       rst_n   = 1'b0;  // Reset, active low
  logic       spiCsN, spiSclk, sdioIn, sdioOut, sdioOe;
  logic       chipEnable, offsetLoopEn, filterBypass;
  logic [2:0] filterCode;
  logic [7:0] rdData;          // Byte returned by a read
  logic       oeSeen;          // Enable seen at the turnaround fall
  logic [7:0] cfg;             // Expected stored word
  int         n_mismatch = 0;
  int         checks     = 0;

  // Clock
  initial forever #5 sys_clk = ~sys_clk;

  fvcsp_top fvcsp_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .chipEnable(chipEnable), .offsetLoopEn(offsetLoopEn),
    .filterCode(filterCode), .filterBypass(filterBypass));

  fvcsp_host_model fvcsp_host_model_inst (.spiCsN(spiCsN), .spiSclk(spiSclk),
    .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe));

  // Counts and verdict, the single end of the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Byte compare
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  // Settings outputs against a stored word; don't-care bits masked off
  task automatic chkSet(input logic [7:0] exp);
    chk8({chipEnable, 2'b00, offsetLoopEn, 1'b0, filterCode}, exp & 8'h97, "settings");
    chk8({7'h00, filterBypass}, {7'h00, exp[2:0] == fvcsp_pkg::CODE_BYPASS}, "bypass");
  endtask : chkSet

  // Write frame of n clocks
  task automatic wr(input logic [7:0] d, input logic [14:0] a, input int n);
    @(negedge sys_clk);
    fvcsp_host_model_inst.frame({1'b0, a, d}, n, rdData, oeSeen);
  endtask : wr

  // Read frame, then byte, turnaround and release compares
  task automatic rdChk(input logic [7:0] exp);
    @(negedge sys_clk);
    fvcsp_host_model_inst.frame({1'b1, fvcsp_pkg::DEV_ADDR, 8'h00}, 24, rdData, oeSeen);
    chk8(rdData, exp, "read");
    chk8({7'h00, oeSeen}, 8'h01, "turnaround");
    chk8({7'h00, sdioOe}, 8'h00, "release");
  endtask : rdChk

  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chkSet(fvcsp_pkg::CFG_RESET);
    rdChk(fvcsp_pkg::CFG_RESET);
    $display("test reset done");
    // Every filter code, enables toggled, incl. offset loop off
    for (int c = 0; c < 8; c++) begin
      cfg = {c[0], 2'b00, c[1], 1'b0, c[2:0]};
      wr(cfg, fvcsp_pkg::DEV_ADDR, 24);
      chkSet(cfg);
      rdChk(cfg);
    end
    $display("test codes done");
    wr(8'h05, fvcsp_pkg::DEV_ADDR, 23);
    chkSet(cfg);
    wr(8'h05, fvcsp_pkg::DEV_ADDR ^ 15'h0001, 24);
    chkSet(cfg);
    rdChk(cfg);
    $display("test refusals done");
    print_verdict();
  end

  // Watchdog: the tests take about 66 us
  initial begin
    #500us;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_fvcsp_top
